// ==== pkg/mac_cfg.svh ====
// Register offsets, field positions, reset values and counts of the multiply unit
`ifndef MAC_CFG_SVH
`define MAC_CFG_SVH

`define MAC_ADR_W        8
`define MAC_OFS_INSTR    8'h00
`define MAC_OFS_STATUS   8'h04
`define MAC_OFS_FLAGS    8'h08
`define MAC_OFS_RESULT   8'h0C
`define MAC_OFS_REGBASE  8'h40
`define MAC_REGSEL_MSB   7
`define MAC_REGSEL_LSB   6
`define MAC_REGSEL_VAL   2'h1

`define MAC_FLAG_N       31
`define MAC_FLAG_Z       30
`define MAC_FLAG_C       29
`define MAC_FLAG_V       28

`define MAC_STAT_BUSY    0
`define MAC_STAT_SKIP    1
`define MAC_STAT_BAD     2
`define MAC_STAT_M_LSB   4

`define MAC_SIG_PATTERN  4'h9
`define MAC_OPC_PATTERN  6'h00
`define MAC_COND_AL      4'hE

`define MAC_FLAGS_RST    32'h0000_0000
`define MAC_RESULT_RST   32'h0000_0000
`define MAC_M_MAX        3'h4
`define MAC_ARRAY_BITS   8
`endif

// ==== pkg/mac_pkg.sv ====
// Types shared by the multiply unit
package mac_pkg;
	// Instruction word as laid out in the 32-bit encoding
	typedef struct packed {
		logic [3:0] cond;
		logic [5:0] opcode;
		logic       accum;
		logic       setflags;
		logic [3:0] rd;
		logic [3:0] addend_reg;
		logic [3:0] multiplier_reg;
		logic [3:0] signature;
		logic [3:0] multiplicand_reg;
	} mac_instr_t;

	typedef struct packed {
		logic n;
		logic z;
		logic c;
		logic v;
	} mac_flags_t;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'h1,
		ST_READ  = 4'h2,
		ST_ARRAY = 4'h4,
		ST_ACCUM = 4'h8
	} mac_state_t;
endpackage : mac_pkg

// ==== hw/mac_unit.sv ====
// Multiply and multiply-accumulate unit with Wishbone register access
// How it works
// - Execute only if condition field is true against current flags, else no effect.
// - Destination 19:16, addend 15:12, multiplier 11:8, multiplicand 3:0, bits 7:4 = 1001.
// - Product formed by an 8-bit Booth multiplier array.
// - Accumulate bit 21 clear: write product, ignore addend field.
// - Accumulate bit set: write product plus addend.
// - Keep only low 32 product bits; serves signed and unsigned.
// - Update flags only when bit 20 is set.
// - Negative gets result bit 31, zero set exactly when result is zero.
// - Carry may be anything, overflow stays unchanged.
// - Multiply takes 1S plus m I cycles, accumulate 1S plus m+1.
// - m is 1 when multiplier bits above 7 are all equal.
// - Else m is 2 when multiplier bits above 15 are all equal.
// - Else m is 3 when bits above 23 all equal, otherwise 4.
// - All other register combinations, including Rd=Rn=Rs, give correct results.
`timescale 1ns/1ps
`include "mac_cfg.svh"

module mac_unit
	import mac_pkg::*;
(
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [`MAC_ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic      [31:0]           wb_dat_o,
	output logic                       wb_ack_o,
	output logic                       busy_o,
	output logic                       done_o
);

	mac_state_t  state;
	mac_instr_t  instr;
	mac_flags_t  current_status_reg;
	logic [31:0] regs [0:15];
	logic [31:0] multiplicand_q;
	logic [31:0] multiplier_q;
	logic [31:0] addend_q;
	logic [31:0] acc;
	logic        prev_bit;
	logic [2:0]  m_cycles;
	logic [2:0]  cyc_left;
	logic [31:0] result;
	logic        skipped;
	logic        bad_form;

	logic        bus_req;
	logic        wr_en;
	logic        rd_en;
	logic        hit_regs;
	logic [3:0]  reg_idx;
	logic        start;
	mac_instr_t  new_instr;
	logic        last_array;
	logic [31:0] booth_term;
	logic        booth_sign;
	logic [31:0] mul_out;
	logic [31:0] final_sum;

	localparam logic [31:0] flags_rst_val = `MAC_FLAGS_RST;

	// Condition code evaluation against N Z C V
	function automatic logic cond_true(input logic [3:0] c, input mac_flags_t f);
		unique case (c)
			4'h0: cond_true = f.z;
			4'h1: cond_true = !f.z;
			4'h2: cond_true = f.c;
			4'h3: cond_true = !f.c;
			4'h4: cond_true = f.n;
			4'h5: cond_true = !f.n;
			4'h6: cond_true = f.v;
			4'h7: cond_true = !f.v;
			4'h8: cond_true = f.c && !f.z;
			4'h9: cond_true = !f.c || f.z;
			4'hA: cond_true = (f.n == f.v);
			4'hB: cond_true = (f.n != f.v);
			4'hC: cond_true = !f.z && (f.n == f.v);
			4'hD: cond_true = f.z || (f.n != f.v);
			4'hE: cond_true = 1'b1;
			4'hF: cond_true = 1'b0;
		endcase
	endfunction : cond_true

	// Early termination: stop once the remaining multiplier bits are pure sign
	function automatic logic [2:0] array_cycles(input logic [31:0] x);
		if (&x[31:8] || ~|x[31:8]) begin
			array_cycles = 3'h1;
		end else if (&x[31:16] || ~|x[31:16]) begin
			array_cycles = 3'h2;
		end else if (&x[31:24] || ~|x[31:24]) begin
			array_cycles = 3'h3;
		end else begin
			array_cycles = `MAC_M_MAX;
		end
	endfunction : array_cycles

	// Booth digit of one 8-bit slice: slice with a chosen sign plus the bit below it
	function automatic logic [31:0] booth_digit(input logic [7:0] s, input logic sg,
			input logic p);
		logic [9:0] d;
		d = {{2{sg}}, s} + {9'h000, p};
		booth_digit = {{22{d[9]}}, d};
	endfunction : booth_digit

	function automatic logic [31:0] byte_merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] sel);
		byte_merge = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				byte_merge[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
	endfunction : byte_merge

	assign bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_en    = bus_req && wb_we_i;
	assign rd_en    = bus_req && !wb_we_i;
	assign hit_regs = (wb_adr_i[`MAC_REGSEL_MSB:`MAC_REGSEL_LSB] == `MAC_REGSEL_VAL);
	assign reg_idx  = wb_adr_i[5:2];
	assign new_instr = mac_instr_t'(wb_dat_i);
	// A new instruction is taken only while idle; writes during an operation are dropped
	assign start    = wr_en && (wb_adr_i == `MAC_OFS_INSTR) && (state == ST_IDLE)
		&& (&wb_sel_i);
	assign last_array = (state == ST_ARRAY) && (cyc_left == 3'h1);
	// Early termination leaves the upper bits unscanned; they are all equal, so the last
	// slice takes its sign from them instead of its own top bit, else 0x80 or 0x..FF14
	// style multipliers would come out wrong by a multiple of the slice weight
	assign booth_sign = last_array ? multiplier_q[8] : multiplier_q[7];
	assign booth_term = (multiplicand_q * booth_digit(multiplier_q[7:0], booth_sign,
		prev_bit));
	assign mul_out    = acc + booth_term;
	assign final_sum  = acc + addend_q;

	// Bus answers one cycle after the request and drops ack the next cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (rd_en) begin
			if (hit_regs) begin
				wb_dat_o <= regs[reg_idx];
			end else begin
				unique case (wb_adr_i)
					`MAC_OFS_INSTR:  wb_dat_o <= instr;
					`MAC_OFS_STATUS: wb_dat_o <= {25'h0000000, m_cycles, 1'b0,
						bad_form, skipped, busy_o};
					`MAC_OFS_FLAGS:  wb_dat_o <= {current_status_reg, 28'h0000000};
					`MAC_OFS_RESULT: wb_dat_o <= result;
					default:         wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Sequencer: one S cycle to read operands, m array cycles, one more to accumulate
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= ST_IDLE;
			instr <= mac_instr_t'(32'h0000_0000);
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (start) begin
						instr <= new_instr;
						state <= ST_READ;
					end
				end
				ST_READ: begin
					if (cond_true(instr.cond, current_status_reg)
							&& instr.signature == `MAC_SIG_PATTERN
							&& instr.opcode == `MAC_OPC_PATTERN) begin
						state <= ST_ARRAY;
					end else begin
						state <= ST_IDLE;
					end
				end
				ST_ARRAY: begin
					if (last_array) begin
						state <= instr.accum ? ST_ACCUM : ST_IDLE;
					end
				end
				ST_ACCUM: state <= ST_IDLE;
				default:  state <= ST_IDLE;
			endcase
		end
	end

	// Operand capture in the S cycle, so later writeback cannot disturb them
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			multiplicand_q <= 32'h0000_0000;
			multiplier_q   <= 32'h0000_0000;
			addend_q       <= 32'h0000_0000;
			prev_bit       <= 1'b0;
			m_cycles       <= 3'h0;
			cyc_left       <= 3'h0;
			acc            <= 32'h0000_0000;
		end else if (state == ST_READ) begin
			multiplicand_q <= regs[instr.multiplicand_reg];
			multiplier_q   <= regs[instr.multiplier_reg];
			addend_q       <= regs[instr.addend_reg];
			prev_bit       <= 1'b0;
			m_cycles       <= array_cycles(regs[instr.multiplier_reg]);
			cyc_left       <= array_cycles(regs[instr.multiplier_reg]);
			acc            <= 32'h0000_0000;
		end else if (state == ST_ARRAY) begin
			// Only 32 bits are kept, which is exact for signed and unsigned operands
			acc            <= acc + booth_term;
			multiplicand_q <= {multiplicand_q[23:0], 8'h00};
			multiplier_q   <= {8'h00, multiplier_q[31:8]};
			prev_bit       <= multiplier_q[7];
			cyc_left       <= cyc_left - 3'h1;
		end
	end

	// Status of the last instruction for software
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			skipped  <= 1'b0;
			bad_form <= 1'b0;
		end else if (state == ST_READ) begin
			skipped  <= !cond_true(instr.cond, current_status_reg);
			bad_form <= (instr.signature != `MAC_SIG_PATTERN)
				|| (instr.opcode != `MAC_OPC_PATTERN);
		end
	end

	// Busy covers the whole instruction; done pulses in the cycle after it ends
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_o <= 1'b0;
			done_o <= 1'b0;
		end else begin
			busy_o <= (state == ST_IDLE) ? start
				: !((state == ST_ACCUM) || (last_array && !instr.accum)
				|| (state == ST_READ && !(cond_true(instr.cond, current_status_reg)
				&& instr.signature == `MAC_SIG_PATTERN
				&& instr.opcode == `MAC_OPC_PATTERN)));
			done_o <= busy_o && !(state == ST_IDLE) && ((state == ST_ACCUM)
				|| (last_array && !instr.accum)
				|| (state == ST_READ && !(cond_true(instr.cond, current_status_reg)
				&& instr.signature == `MAC_SIG_PATTERN
				&& instr.opcode == `MAC_OPC_PATTERN)));
		end
	end

	// Result register holds the last written value
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			result <= `MAC_RESULT_RST;
		end else if (last_array && !instr.accum) begin
			result <= mul_out;
		end else if (state == ST_ACCUM) begin
			result <= final_sum;
		end
	end

	// Register file: writeback only after the final cycle; bus writes refused while busy
	always_ff @(posedge clk_i) begin
		if (last_array && !instr.accum) begin
			regs[instr.rd] <= mul_out;
		end else if (state == ST_ACCUM) begin
			regs[instr.rd] <= final_sum;
		end else if (wr_en && hit_regs && state == ST_IDLE && !start) begin
			regs[reg_idx] <= byte_merge(regs[reg_idx], wb_dat_i, wb_sel_i);
		end
	end

	// Flags: N and Z from the result, C left as it was, C and V written here only by a bus write to the flags register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			current_status_reg <= mac_flags_t'(flags_rst_val[`MAC_FLAG_N:`MAC_FLAG_V]);
		end else if (instr.setflags && last_array && !instr.accum) begin
			current_status_reg.n <= mul_out[31];
			current_status_reg.z <= (mul_out == 32'h0000_0000);
		end else if (instr.setflags && state == ST_ACCUM) begin
			current_status_reg.n <= final_sum[31];
			current_status_reg.z <= (final_sum == 32'h0000_0000);
		end else if (wr_en && wb_adr_i == `MAC_OFS_FLAGS && state == ST_IDLE
				&& wb_sel_i[3]) begin
			current_status_reg <= mac_flags_t'(wb_dat_i[`MAC_FLAG_N:`MAC_FLAG_V]);
		end
	end

endmodule : mac_unit

// ==== verification/mac_issuer.sv ====
// Issuer model: Wishbone master standing in for the instruction decoder
`timescale 1ns/1ps
`include "mac_cfg.svh"

module mac_issuer (
	input  wire logic                  clk_i,
	input  wire logic                  ack_i,
	input  wire logic [31:0]           dat_i,
	output logic                       cyc_o,
	output logic                       we_o,
	output logic [`MAC_ADR_W-1:0]      adr_o,
	output logic [31:0]                dat_o,
	output logic                       tmo_o
);
	initial {cyc_o, we_o, adr_o, dat_o, tmo_o} = '0;

	// Entered at a rising edge; returns one idle edge after the ack edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		cyc_o <= 1'b1;
		we_o  <= w;
		adr_o <= a;
		dat_o <= d;
		@(posedge clk_i);
		while (!ack_i && n < 50) begin
			n++;
			@(posedge clk_i);
		end
		q = dat_i;
		tmo_o = tmo_o | !ack_i;
		cyc_o <= 1'b0;
		// Released data must not look like the old value
		dat_o <= ~d;
		@(posedge clk_i);
	endtask : xfer
endmodule : mac_issuer

// ==== verification/mac_unit_asserts.sv ====
// Port-level checks of the multiply unit
`timescale 1ns/1ps
`include "mac_cfg.svh"

module mac_unit_asserts (
	input wire logic                  clk_i,
	input wire logic                  rst_i,
	input wire logic                  wb_cyc_i,
	input wire logic                  wb_stb_i,
	input wire logic                  wb_we_i,
	input wire logic [`MAC_ADR_W-1:0] wb_adr_i,
	input wire logic [3:0]            wb_sel_i,
	input wire logic [31:0]           wb_dat_i,
	input wire logic [31:0]           wb_dat_o,
	input wire logic                  wb_ack_o,
	input wire logic                  busy_o,
	input wire logic                  done_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic req;
	logic start;
	assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign start = req && wb_we_i && wb_adr_i == `MAC_OFS_INSTR && wb_sel_i == 4'hF && !busy_o;

	property p_ack_one;   req |=> wb_ack_o; endproperty
	property p_ack_drop;  wb_ack_o |=> !wb_ack_o; endproperty
	property p_ack_cause; wb_ack_o |-> $past(req); endproperty
	property p_start;     start |=> busy_o; endproperty
	property p_quiet;     !busy_o && !start |=> !busy_o; endproperty
	property p_busy_max;  $rose(busy_o) |-> ##[1:6] !busy_o; endproperty
	property p_done_after; !$past(rst_i) && $fell(busy_o) |-> done_o; endproperty
	property p_done_cause; done_o |-> $past(busy_o) && !busy_o; endproperty

	a_ack_one: assert property (p_ack_one) else $error("ack not one cycle after request");
	a_ack_drop: assert property (p_ack_drop) else $error("ack longer than one cycle");
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	a_start: assert property (p_start) else $error("busy missing after start");
	a_quiet: assert property (p_quiet) else $error("busy without start");
	a_busy_max: assert property (p_busy_max) else $error("busy too long");
	a_done_after: assert property (p_done_after) else $error("no done after busy");
	a_done_cause: assert property (p_done_cause) else $error("stray done");

	c_start: cover property (start);
	c_long: cover property ($rose(busy_o) ##1 busy_o [*4]);
	c_read: cover property (wb_ack_o && !wb_we_i);
endmodule : mac_unit_asserts

bind mac_unit mac_unit_asserts i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .busy_o, .done_o);

// ==== verification/tb_top.sv ====
// Self-checking testbench of the multiply unit
`timescale 1ns/1ps
`include "mac_cfg.svh"

module tb_top
	import mac_pkg::*;
;
	logic        clk_i;
	logic        rst_i;
	logic        cyc;
	logic        we;
	logic        ack;
	logic        busy;
	logic        done;
	logic        tmo;
	logic [7:0]  adr;
	logic [31:0] wd;
	logic [31:0] rdat;
	int          err_total;
	int          n_tests;
	int          nb;

	mac_unit i_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rdat),
		.wb_ack_o(ack), .busy_o(busy), .done_o(done));
	mac_issuer i_iss (.clk_i, .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .we_o(we),
		.adr_o(adr), .dat_o(wd), .tmo_o(tmo));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) if (busy) nb <= nb + 1;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic test_done();
		$display("checks=%0d mismatches=%0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : test_done

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		i_iss.xfer(w, a, d, q);
		if (tmo) begin
			err_total++;
			test_done();
		end
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q & msk, e);
	endtask : rd

	function automatic logic [7:0] ra(input logic [3:0] n);
		ra = `MAC_OFS_REGBASE + {2'h0, n, 2'h0};
	endfunction : ra

	function automatic mac_instr_t ins(input logic [3:0] c, input logic a, input logic s,
		input logic [3:0] d, input logic [3:0] n);
		// Multiplier from R2, multiplicand from R1, never R15; Rd is chosen by the caller and may be R2
		ins = '{c, 6'h00, a, s, d, n, 4'h2, `MAC_SIG_PATTERN, 4'h1};
	endfunction : ins

	// Counts busy cycles of one instruction and waits for its done pulse
	task automatic run(input mac_instr_t i, input int c);
		int n;
		n = 0;
		nb = 0;
		wr(`MAC_OFS_INSTR, i);
		while (done !== 1'b1) begin
			n++;
			if (n > 30) begin
				err_total++;
				test_done();
			end
			@(posedge clk_i);
		end
		chk(nb, c);
	endtask : run

	task automatic t_bus();
		wr(8'h20, 32'hFFFF_FFFF);
		rd(8'h20, '1, 32'h0);
	endtask : t_bus

	task automatic t_mul();
		logic [31:0] rs [4];
		logic [31:0] p;
		rs = '{32'hFFFF_FF14, 32'h0000_1234, 32'hFF80_0000, 32'h1234_5678};
		for (int k = 0; k < 8; k++) begin
			p = 32'hFFFF_FFF6 * rs[k%4];
			wr(ra(4'h1), 32'hFFFF_FFF6);
			wr(ra(4'h2), rs[k%4]);
			if (k < 4) begin
				run(ins(`MAC_COND_AL, 1'b0, 1'b0, 4'h4, 4'h0), k + 2);
				rd(ra(4'h4), '1, p);
				rd(`MAC_OFS_STATUS, 32'h0000_0077, 32'(k + 1) << 4);
			end else begin
				run(ins(`MAC_COND_AL, 1'b1, 1'b0, 4'h2, 4'h2), k - 1);
				rd(ra(4'h2), '1, p + rs[k%4]);
			end
		end
	endtask : t_mul

	task automatic t_flags();
		wr(`MAC_OFS_FLAGS, 32'h1000_0000);
		wr(ra(4'h2), 32'h0000_0014);
		run(ins(`MAC_COND_AL, 1'b0, 1'b1, 4'h4, 4'h0), 2);
		rd(ra(4'h4), '1, 32'hFFFF_FF38);
		rd(`MAC_OFS_FLAGS, 32'hD000_0000, 32'h9000_0000);
		wr(ra(4'h1), 32'h0);
		run(ins(`MAC_COND_AL, 1'b0, 1'b1, 4'h4, 4'h0), 2);
		rd(`MAC_OFS_FLAGS, 32'hD000_0000, 32'h5000_0000);
		wr(`MAC_OFS_FLAGS, 32'hA000_0000);
		wr(ra(4'h1), 32'hFFFF_FFF6);
		run(ins(`MAC_COND_AL, 1'b0, 1'b0, 4'h4, 4'h0), 2);
		rd(`MAC_OFS_FLAGS, 32'hF000_0000, 32'hA000_0000);
	endtask : t_flags

	// Relies on R1 and R2 as left by the flag scenario
	task automatic t_cond();
		mac_instr_t i;
		wr(`MAC_OFS_FLAGS, 32'h4000_0000);
		wr(ra(4'h4), 32'h5A5A_5A5A);
		run(ins(4'h1, 1'b0, 1'b0, 4'h4, 4'h0), 1);
		rd(ra(4'h4), '1, 32'h5A5A_5A5A);
		rd(`MAC_OFS_STATUS, 32'h0000_0007, 32'h0000_0002);
		i = ins(`MAC_COND_AL, 1'b0, 1'b0, 4'h4, 4'h0);
		i.signature = 4'h8;
		run(i, 1);
		rd(ra(4'h4), '1, 32'h5A5A_5A5A);
		rd(`MAC_OFS_STATUS, 32'h0000_0007, 32'h0000_0004);
		run(ins(4'h0, 1'b0, 1'b0, 4'h4, 4'h0), 2);
		rd(ra(4'h4), '1, 32'hFFFF_FF38);
		rd(`MAC_OFS_RESULT, '1, 32'hFFFF_FF38);
		rd(`MAC_OFS_STATUS, 32'h0000_0077, 32'h0000_0010);
	endtask : t_cond

	initial begin
		err_total = 0;
		n_tests = 0;
		nb = 0;
		rst_i = 1'b1;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_bus();
		t_mul();
		t_flags();
		t_cond();
		test_done();
	end
endmodule : tb_top
